// ---- design/i2c_abort_hold.sv ----
// Purpose: SDA hold timing and transmit abort cause capture of an I2C controller
// Assumes: abort events arrive as one-cycle pulses from controller logic on clk
// Notes: SCL and SDA pins pass two flops before any use
// Overview of operation
// (R1) Receiver drives SDA after the 8-bit receive hold count.
// (R2) Transmitter drives SDA after the 16-bit transmit hold count.
// (R3) Reading either clear register clears all causes except start-byte bit.
// (R4) Software fixes start-byte source via restart, command bit, or select bit.
// (R5) Clearing start-byte bit with source present drops one cycle, then reasserts.
// (R6) Three-bit flushed command count; cleared while controller disabled.
// (R7) Master flags SDA stuck low after the programmed timeout count.
// (R8) Master flags user abort when software sets enable bit one.
// (R9) Flag slave asked to transmit in invalid read scenario.
// (R10) Slave transmit mismatch at SCL rise sets lost-bus and arbitration bits.
// (R11) Slave read with stale transmit data raises flush abort and cause.
// (R12) Arbitration bit set on master loss or with slave lost-bus.
// (R13) Flag master operation attempted while master mode disabled.
// (R14) Flag 10-bit read while restart disabled.
// (R15) Flag start byte attempt while restart disabled.
// (R16) Flag high speed transfer attempt while restart disabled.
// (R17) Flag acknowledged start byte.
// (R18) Flag acknowledged high speed master code.
// (R19) Flag general call followed by a read command.
// (R20) Flag general call not acknowledged.
// (R21) Flag data byte not acknowledged after acknowledged address.
// (R22) Separate flags for 7-bit and both 10-bit address bytes unacknowledged.
// (R23) Hold register writable only while controller enable is zero.
// (R24) Transmit hold must stay between mode minimum and SCL low minus two; writes store any 16-bit value unchecked.
// (R25) Any set cause raises the raw transmit abort flag.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
module i2c_abort_hold (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe,
	input wire logic master_active,
	input wire logic slave_tx_active,
	input wire logic device_tx,
	input wire logic sda_want,
	input wire logic master_op_req,
	input wire logic read_10bit_req,
	input wire logic startbyte_req,
	input wire logic hs_req,
	input wire logic ev_master_arbitration_lost_cause,
	input wire logic ev_slave_read_cmd,
	input wire logic tx_fifo_nonempty,
	input wire logic ev_slave_read_invalid,
	input wire logic ev_startbyte_acked,
	input wire logic ev_hs_code_acked,
	input wire logic ev_gencall_then_read,
	input wire logic ev_gencall_nack,
	input wire logic ev_data_nack,
	input wire logic ev_sevenbit_nack,
	input wire logic ev_tenbit_first_nack,
	input wire logic ev_tenbit_second_nack,
	input wire logic ev_cmd_flushed,
	output logic transmit_abort_flag,
	output logic flush_request,
	output logic controller_enable
);
	import i2c_hold_pkg::*;

	typedef struct packed {
		bus_phase_t phase;
		logic [ADDR_W-1:0] addr;
		logic [31:0] hrdata;
		logic [TX_HOLD_W-1:0] tx_hold;
		logic [RX_HOLD_W-1:0] rx_hold;
		logic [CAUSE_W-1:0] cause;
		logic [FLUSH_W-1:0] flush_cnt;
		logic sb_dropped;
		logic master_en;
		logic restart_allow;
		logic gencall_or_startbyte_sel;
		logic command_bit_a;
		logic enable;
		logic [31:0] sda_low_timeout;
		logic [31:0] stuck_cnt;
		logic scl_meta;
		logic scl_sync;
		logic scl_prev;
		logic sda_meta;
		logic sda_sync;
		logic abort_flag;
		logic flush_request;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next_s;

	logic accept;
	logic clr_read;
	logic user_write;
	logic scl_rise;
	logic scl_fall;
	logic sb_source;
	logic stuck_hit;
	logic slave_mismatch;
	logic slave_flush;
	logic [CAUSE_W-1:0] set_vec;
	logic [31:0] read_value;

	hold_if #(.W(TX_HOLD_W)) hif ();

	sda_hold_delay #(.W(TX_HOLD_W)) u_hold (
		.clk(clk),
		.rst_n(rst_n),
		.hif(hif)
	);

	function automatic logic [31:0] read_mux(input ctrl_state_t st);
		logic [31:0] v;
		v = '0;
		case (st.addr)
			ADDR_SDA_HOLD: begin
				v[TX_HOLD_W-1:0] = st.tx_hold;
				v[RX_HOLD_LSB +: RX_HOLD_W] = st.rx_hold;
			end
			ADDR_ABORT_CAUSE: begin
				v[CAUSE_W-1:0] = st.cause;
				v[FLUSH_LSB +: FLUSH_W] = st.flush_cnt;
			end
			ADDR_CONTROL: begin
				v[CTRL_MASTER_EN] = st.master_en;
				v[CTRL_RESTART] = st.restart_allow;
			end
			ADDR_TARGET: begin
				v[TGT_GENCALL_SEL] = st.gencall_or_startbyte_sel;
				v[TGT_COMMAND_A] = st.command_bit_a;
			end
			ADDR_ENABLE: v[EN_ENABLE] = st.enable;
			ADDR_LOW_TIMEOUT: v = st.sda_low_timeout;
			ADDR_CLR_ABORT, ADDR_CLR_ALL: v[0] = st.abort_flag;
			default: v = '0;
		endcase
		return v;
	endfunction : read_mux

	// Address phase taken only when the bus is ready
	assign accept = hsel && (htrans == HTRANS_NONSEQ) && hready;
	assign read_value = read_mux(s);
	assign scl_rise = s.scl_sync && !s.scl_prev;
	assign scl_fall = !s.scl_sync && s.scl_prev;
	// (R3) clear on read of either clear register
	assign clr_read = (s.phase == PH_READ_WAIT) &&
		((s.addr == ADDR_CLR_ABORT) || (s.addr == ADDR_CLR_ALL));
	assign user_write = (s.phase == PH_WRITE) && (s.addr == ADDR_ENABLE) && hwdata[EN_ABORT];
	// (R4) source remains until one of three fixes
	assign sb_source = !s.restart_allow && s.command_bit_a && s.gencall_or_startbyte_sel;
	// (R7) stuck low for the full timeout
	assign stuck_hit = master_active && !s.sda_sync && (s.sda_low_timeout != '0) &&
		(s.stuck_cnt == s.sda_low_timeout - 32'h1);
	// (R10) bus level differs from the bit we released or drove
	assign slave_mismatch = scl_rise && slave_tx_active && (s.sda_sync != !hif.drive_low);
	// (R11) stale transmit data on a slave read
	assign slave_flush = ev_slave_read_cmd && tx_fifo_nonempty;

	// (R22) address not acknowledged
	assign set_vec[BIT_SEVENBIT_NACK] = ev_sevenbit_nack;
	assign set_vec[BIT_TENBIT_FIRST_NACK] = ev_tenbit_first_nack;
	assign set_vec[BIT_TENBIT_SECOND_NACK] = ev_tenbit_second_nack;
	// (R21) data byte refused
	assign set_vec[BIT_DATA_NACK] = ev_data_nack;
	// (R20) general call refused
	assign set_vec[BIT_GENCALL_NACK] = ev_gencall_nack;
	// (R19) read queued after general call
	assign set_vec[BIT_GENCALL_READ] = ev_gencall_then_read;
	// (R18) master code acknowledged
	assign set_vec[BIT_HS_CODE_ACKED] = ev_hs_code_acked;
	// (R17) start byte acknowledged
	assign set_vec[BIT_STARTBYTE_ACKED] = ev_startbyte_acked;
	// (R16) high speed without restart
	assign set_vec[BIT_HIGHSPEED_NORESTART] = hs_req && !s.restart_allow;
	// (R15) start byte without restart
	assign set_vec[BIT_STARTBYTE_NORESTART] = startbyte_req && !s.restart_allow;
	// (R14) 10-bit read without restart
	assign set_vec[BIT_TENBIT_READ_NORESTART] = read_10bit_req && !s.restart_allow;
	// (R13) master operation while disabled
	assign set_vec[BIT_MASTER_DISABLED] = master_op_req && !s.master_en;
	// (R12) master or slave arbitration loss
	assign set_vec[BIT_ARBITRATION] = ev_master_arbitration_lost_cause || slave_mismatch;
	assign set_vec[BIT_SLAVE_FLUSH] = slave_flush;
	assign set_vec[BIT_SLAVE_LOST_BUS] = slave_mismatch;
	// (R9) invalid slave read scenario
	assign set_vec[BIT_SLAVE_READ_TX] = ev_slave_read_invalid;
	// (R8) user abort only counts in master mode
	assign set_vec[BIT_USER_ABORT] = user_write && master_active;
	assign set_vec[BIT_SDA_STUCK] = stuck_hit;

	// (R1) receive hold count while receiving
	// (R2) transmit hold count while transmitting
	assign hif.hold_cycles = device_tx ? s.tx_hold : TX_HOLD_W'(s.rx_hold);
	assign hif.scl_fall = scl_fall;
	assign hif.want = sda_want;

	always_comb begin
		next_s = s;
		next_s.scl_meta = scl_in;
		next_s.scl_sync = s.scl_meta;
		next_s.scl_prev = s.scl_sync;
		next_s.sda_meta = sda_in;
		next_s.sda_sync = s.sda_meta;
		next_s.flush_request = slave_flush;
		if (s.phase == PH_WRITE) begin
			case (s.addr)
				ADDR_SDA_HOLD: begin
					// (R23) locked while enabled
					if (!s.enable) begin
						next_s.tx_hold = hwdata[TX_HOLD_W-1:0];
						next_s.rx_hold = hwdata[RX_HOLD_LSB +: RX_HOLD_W];
					end
				end
				ADDR_CONTROL: begin
					next_s.master_en = hwdata[CTRL_MASTER_EN];
					next_s.restart_allow = hwdata[CTRL_RESTART];
				end
				ADDR_TARGET: begin
					next_s.gencall_or_startbyte_sel = hwdata[TGT_GENCALL_SEL];
					next_s.command_bit_a = hwdata[TGT_COMMAND_A];
				end
				ADDR_ENABLE: next_s.enable = hwdata[EN_ENABLE];
				ADDR_LOW_TIMEOUT: next_s.sda_low_timeout = hwdata;
				default: ;
			endcase
		end
		case (s.phase)
			PH_READ_WAIT: begin
				next_s.hrdata = read_value;
				next_s.phase = PH_READ_DONE;
			end
			default: begin
				if (accept) begin
					next_s.addr = haddr[ADDR_W-1:0];
					next_s.phase = hwrite ? PH_WRITE : PH_READ_WAIT;
				end else begin
					next_s.phase = PH_IDLE;
				end
			end
		endcase
		// (R7) count low cycles, saturating at the timeout
		if (master_active && !s.sda_sync) begin
			if (s.stuck_cnt != s.sda_low_timeout) begin
				next_s.stuck_cnt = s.stuck_cnt + 32'h1;
			end
		end else begin
			next_s.stuck_cnt = '0;
		end
		// (R5) drop now, reassert next cycle if source still there
		next_s.sb_dropped = 1'b0;
		if (clr_read) begin
			next_s.cause = '0;
			// Only a cause bit that was set can bounce back
			next_s.sb_dropped = sb_source && s.cause[BIT_STARTBYTE_NORESTART];
		end
		if (s.sb_dropped && sb_source) begin
			next_s.cause[BIT_STARTBYTE_NORESTART] = 1'b1;
		end
		// New events win over a clear in the same cycle
		next_s.cause = next_s.cause | set_vec;
		// (R25) raw abort flag follows the cause bits
		next_s.abort_flag = |next_s.cause;
		// (R6) flushed commands, saturating, zero while disabled
		if (!s.enable) begin
			next_s.flush_cnt = '0;
		end else if (ev_cmd_flushed && (s.flush_cnt != '1)) begin
			next_s.flush_cnt = s.flush_cnt + FLUSH_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.tx_hold <= HOLD_RESET[TX_HOLD_W-1:0];
			s.rx_hold <= HOLD_RESET[RX_HOLD_LSB +: RX_HOLD_W];
			s.sda_low_timeout <= TIMEOUT_RESET;
			s.scl_meta <= 1'b1;
			s.scl_sync <= 1'b1;
			s.scl_prev <= 1'b1;
			s.sda_meta <= 1'b1;
			s.sda_sync <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Reads cost one wait state so a write just before is always seen
	assign hreadyout = (s.phase != PH_READ_WAIT);
	assign hrdata = s.hrdata;
	assign hresp = HRESP_OKAY;
	assign sda_o = 1'b0;
	assign sda_oe = hif.drive_low;
	assign transmit_abort_flag = s.abort_flag;
	assign flush_request = s.flush_request;
	assign controller_enable = s.enable;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_hold_write_lock: // (R23)
	assert property ((s.phase == PH_WRITE) && (s.addr == ADDR_SDA_HOLD) && s.enable
		|=> $stable(s.tx_hold) && $stable(s.rx_hold))
		else $error("hold register changed while enabled");

	a_clear_on_read: // (R3)
	assert property (clr_read
		|=> ((s.cause & ~$past(set_vec) & CLEAR_MASK) == '0))
		else $error("cause bits survived a clear read");

	a_sbyte_drop: // (R5)
	assert property (clr_read && !set_vec[BIT_STARTBYTE_NORESTART]
		|=> !s.cause[BIT_STARTBYTE_NORESTART])
		else $error("start byte cause did not drop on clear");

	a_sbyte_return: // (R5)
	assert property ((clr_read && sb_source && s.cause[BIT_STARTBYTE_NORESTART])
		##1 sb_source
		|=> s.cause[BIT_STARTBYTE_NORESTART])
		else $error("start byte cause did not reassert");

	a_flush_disabled: // (R6)
	assert property (!s.enable |=> (s.flush_cnt == '0))
		else $error("flush count kept while disabled");

	a_stuck_timeout: // (R7)
	assert property (stuck_hit |=> s.cause[BIT_SDA_STUCK] ##1 s.abort_flag)
		else $error("stuck low not flagged");

	a_user_abort_master: // (R8)
	assert property (user_write && !master_active && !$past(s.cause[BIT_USER_ABORT])
		&& !s.cause[BIT_USER_ABORT] |=> !s.cause[BIT_USER_ABORT])
		else $error("user abort flagged outside master mode");

	a_slave_lost_pair: // (R10)
	assert property (slave_mismatch
		|=> s.cause[BIT_SLAVE_LOST_BUS] && s.cause[BIT_ARBITRATION])
		else $error("slave loss did not set both bits");

	a_norestart_read: // (R14)
	assert property (read_10bit_req && !s.restart_allow |=> s.cause[BIT_TENBIT_READ_NORESTART])
		else $error("10-bit read without restart not flagged");

	a_abort_flag_level: // (R25)
	assert property ((|set_vec) |=> transmit_abort_flag)
		else $error("new cause did not raise abort flag");

	a_read_wait_state:
	assert property ((s.phase == PH_READ_WAIT) |-> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong length");

	c_clear_read: cover property (clr_read ##1 s.cause == '0);
	c_sbyte_bounce: cover property ((clr_read && sb_source) ##2 s.cause[BIT_STARTBYTE_NORESTART]);
	c_slave_lost: cover property (slave_mismatch);
	c_stuck_low: cover property (stuck_hit);
endmodule : i2c_abort_hold

// ---- design/i2c_hold_pkg.sv ----
// Purpose: shared constants for the SDA hold and abort cause block
// Assumes: 32-bit AHB-Lite register bus decoded on the low address byte
// Notes: cause bit positions follow the abort cause register layout
package i2c_hold_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_SDA_HOLD = 8'h7C;
	localparam logic [7:0] ADDR_ABORT_CAUSE = 8'h80;
	localparam logic [7:0] ADDR_CONTROL = 8'hA0;
	localparam logic [7:0] ADDR_TARGET = 8'hA4;
	localparam logic [7:0] ADDR_ENABLE = 8'hA8;
	localparam logic [7:0] ADDR_LOW_TIMEOUT = 8'hAC;
	localparam logic [7:0] ADDR_CLR_ABORT = 8'hB0;
	localparam logic [7:0] ADDR_CLR_ALL = 8'hB4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int TX_HOLD_W = 16;
	localparam int RX_HOLD_W = 8;
	localparam int RX_HOLD_LSB = 16;
	localparam logic [31:0] HOLD_RESET = 32'h00000001;
	localparam logic [31:0] TIMEOUT_RESET = 32'h0000FFFF;
	localparam int FLUSH_LSB = 23;
	localparam int FLUSH_W = 3;
	localparam int CAUSE_W = 18;
	localparam int BIT_SEVENBIT_NACK = 0;
	localparam int BIT_TENBIT_FIRST_NACK = 1;
	localparam int BIT_TENBIT_SECOND_NACK = 2;
	localparam int BIT_DATA_NACK = 3;
	localparam int BIT_GENCALL_NACK = 4;
	localparam int BIT_GENCALL_READ = 5;
	localparam int BIT_HS_CODE_ACKED = 6;
	localparam int BIT_STARTBYTE_ACKED = 7;
	localparam int BIT_HIGHSPEED_NORESTART = 8;
	localparam int BIT_STARTBYTE_NORESTART = 9;
	localparam int BIT_TENBIT_READ_NORESTART = 10;
	localparam int BIT_MASTER_DISABLED = 11;
	localparam int BIT_ARBITRATION = 12;
	localparam int BIT_SLAVE_FLUSH = 13;
	localparam int BIT_SLAVE_LOST_BUS = 14;
	localparam int BIT_SLAVE_READ_TX = 15;
	localparam int BIT_USER_ABORT = 16;
	localparam int BIT_SDA_STUCK = 17;
	localparam logic [CAUSE_W-1:0] CLEAR_MASK = ~(CAUSE_W'(1) << BIT_STARTBYTE_NORESTART);
	localparam int CTRL_MASTER_EN = 0;
	localparam int CTRL_RESTART = 5;
	localparam int TGT_GENCALL_SEL = 10;
	localparam int TGT_COMMAND_A = 11;
	localparam int EN_ENABLE = 0;
	localparam int EN_ABORT = 1;
	typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ_WAIT, PH_READ_DONE} bus_phase_t;
endpackage : i2c_hold_pkg

// ---- design/hold_if.sv ----
// Purpose: carries the SDA hold request between the controller and its delay line
// Assumes: all signals on the controller clock
// Notes: drive_low high means SDA is pulled low
`timescale 1ns/1ns
interface hold_if #(parameter int W = 16);
	logic scl_fall;
	logic [W-1:0] hold_cycles;
	logic want;
	logic drive_low;
	modport ctl (output scl_fall, output hold_cycles, output want, input drive_low);
	modport dly (input scl_fall, input hold_cycles, input want, output drive_low);
endinterface : hold_if

// ---- design/sda_hold_delay.sv ----
// Purpose: delays an SDA change by a programmed count after each SCL fall
// Assumes: scl_fall is a single-cycle pulse from synchronised SCL
// Notes: a count of zero behaves as one cycle
`timescale 1ns/1ns
module sda_hold_delay #(parameter int W = 16) (
	input wire logic clk,
	input wire logic rst_n,
	hold_if.dly hif
);
	import i2c_hold_pkg::*;

	typedef struct packed {
		logic busy;
		logic [W-1:0] cnt;
		logic drive_low;
	} hold_state_t;

	hold_state_t s;
	hold_state_t next_s;

	always_comb begin
		next_s = s;
		if (hif.scl_fall) begin
			next_s.busy = 1'b1;
			next_s.cnt = hif.hold_cycles;
		end else if (s.busy) begin
			if (s.cnt <= W'(1)) begin
				next_s.busy = 1'b0;
				next_s.drive_low = !hif.want;
			end else begin
				next_s.cnt = s.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign hif.drive_low = s.drive_low;
endmodule : sda_hold_delay

// ---- dv/i2c_remote_party.sv ----
// Purpose: remote party on the I2C wires, clocking SCL in frames and able to hold SDA low
// Assumes: both wires are open drain with pull-ups
// Notes: SCL stands high between frames; frames start off the bench clock grid
`timescale 1ns/1ns
module i2c_remote_party (
	input wire logic run_scl,
	input wire logic pull_low,
	input wire logic sda_oe,
	output logic scl_in,
	output logic sda_in
);
	initial scl_in = 1'b1;
	always begin
		if (run_scl) begin
			#80 scl_in = 1'b0;
			#80 scl_in = 1'b1;
		end else begin
			scl_in = 1'b1;
			@(posedge run_scl);
			// Off the clock grid so the synchronisers see no race
			#1;
		end
	end
	// Released line floats to the pull-up level
	assign sda_in = ~(sda_oe | pull_low);
endmodule : i2c_remote_party

// ---- dv/tb_i2c_abort_hold.sv ----
// Purpose: self-checking bench for the SDA hold and abort cause block
// Assumes: one bus slave, hready looped back from hreadyout
// Notes: random picks come from a 16-bit LFSR with a fixed seed
`timescale 1ns/1ns
module tb_i2c_abort_hold;
	import i2c_hold_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] CNT = 32'h03800000;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp, sda_o, sda_oe;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, hv;
	logic [1:0] htrans = 0;
	logic scl_in, sda_in, transmit_abort_flag, flush_request, controller_enable;
	logic master_active = 0, slave_tx_active = 0, device_tx = 0, sda_want = 1;
	logic sb = 0, src = 0, fifo = 0, efl = 0, run_scl = 0, pull_low = 0;
	logic [12:0] pv = 0;
	logic [15:0] lf = 16'hEAAA;
	int mismatches = 0, checks_done = 0, cyc = 0, lows = 0, t, i;
	int eb[13] = '{11, 10, 8, 12, 15, 7, 6, 5, 4, 3, 0, 1, 2};

	i2c_abort_hold uut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .scl_in, .sda_in, .sda_o, .sda_oe,
		.master_active, .slave_tx_active, .device_tx, .sda_want, .master_op_req(pv[0]),
		.read_10bit_req(pv[1]), .startbyte_req(sb), .hs_req(pv[2]),
		.ev_master_arbitration_lost_cause(pv[3]), .ev_slave_read_cmd(src), .tx_fifo_nonempty(fifo),
		.ev_slave_read_invalid(pv[4]), .ev_startbyte_acked(pv[5]), .ev_hs_code_acked(pv[6]),
		.ev_gencall_then_read(pv[7]), .ev_gencall_nack(pv[8]), .ev_data_nack(pv[9]),
		.ev_sevenbit_nack(pv[10]), .ev_tenbit_first_nack(pv[11]),
		.ev_tenbit_second_nack(pv[12]), .ev_cmd_flushed(efl), .transmit_abort_flag,
		.flush_request, .controller_enable);
	i2c_remote_party party (.run_scl, .pull_low, .sda_oe, .scl_in, .sda_in);

	initial forever #2 clk = ~clk;

	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	function automatic logic [31:0] bitv(input int b);
		return 32'h1 << b;
	endfunction : bitv

	task automatic complete_run;
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(negedge clk); while (hreadyout !== 1'b1);
		@(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(negedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge clk);
	endtask : bus
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		check(rd & m, e);
		check({31'h0, hresp}, 32'h0);
	endtask : rchk
	task automatic flagchk(input logic e);
		@(negedge clk);
		check({31'h0, transmit_abort_flag}, {31'h0, e});
		@(posedge clk);
	endtask : flagchk
	task automatic hold(input int h, input logic tx);
		int n;
		n = 0;
		device_tx <= tx;
		run_scl <= 1'b1;
		@(negedge scl_in);
		@(posedge clk);
		sda_want <= ~sda_want;
		do begin
			@(negedge clk);
			n++;
		end while (sda_oe === sda_want && n < 100);
		@(posedge clk);
		run_scl <= 1'b0;
		// Window covers the synchroniser and edge detect delay
		check(32'(n >= h + 1 && n <= h + 5), 32'h1);
		check({31'h0, sda_o}, 32'h0);
		// Let the frame finish so SCL stands high before the next one
		repeat (50) @(posedge clk);
	endtask : hold
	task automatic flushes(input int n);
		repeat (n) begin
			efl <= 1'b1;
			@(posedge clk);
			efl <= 1'b0;
			@(posedge clk);
		end
	endtask : flushes

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	always @(negedge clk) if (transmit_abort_flag === 1'b0) lows++;

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(ADDR_SDA_HOLD, ALL, 32'h00000001);
		rchk(ADDR_ABORT_CAUSE, ALL, 32'h0);
		rchk(8'h40, ALL, 32'h0);
		bus(ADDR_CONTROL, 1'b1, 32'h0);
		for (int k = 0; k < 3; k++) begin
			lf = nx(lf);
			// hold kept below SCL low minus two
			t = 2 + int'(lf[2:0]);
			hv = {8'h0, 8'(t + 8), 16'(t)};
			bus(ADDR_SDA_HOLD, 1'b1, hv);
			rchk(ADDR_SDA_HOLD, ALL, hv);
			hold(t, 1'b1);
			hold(t + 8, 1'b0);
		end
		slave_tx_active <= 1'b1;
		device_tx <= 1'b1;
		sda_want <= 1'b1;
		pull_low <= 1'b1;
		run_scl <= 1'b1;
		@(posedge scl_in);
		repeat (8) @(posedge clk);
		run_scl <= 1'b0;
		pull_low <= 1'b0;
		slave_tx_active <= 1'b0;
		rchk(ADDR_ABORT_CAUSE, 32'h5000, 32'h5000);
		bus(ADDR_CLR_ALL, 1'b0, 32'h0);
		// Abort request outside master mode must not flag
		bus(ADDR_ENABLE, 1'b1, 32'h2);
		rchk(ADDR_ABORT_CAUSE, ALL, 32'h0);
		master_active <= 1'b1;
		bus(ADDR_LOW_TIMEOUT, 1'b1, 32'h28);
		pull_low <= 1'b1;
		repeat (20) @(posedge clk);
		rchk(ADDR_ABORT_CAUSE, bitv(17), 32'h0);
		repeat (30) @(posedge clk);
		rchk(ADDR_ABORT_CAUSE, bitv(17), bitv(17));
		pull_low <= 1'b0;
		bus(ADDR_LOW_TIMEOUT, 1'b1, 32'h0);
		bus(ADDR_CLR_ABORT, 1'b0, 32'h0);
		for (int k = 0; k < 26; k++) begin
			lf = nx(lf);
			i = (k < 13) ? k : int'(lf) % 13;
			pv[i] <= 1'b1;
			@(posedge clk);
			pv <= 13'h0;
			@(posedge clk);
			rchk(ADDR_ABORT_CAUSE, 32'h3FFFF, bitv(eb[i]));
			flagchk(1'b1);
			bus(k[0] ? ADDR_CLR_ALL : ADDR_CLR_ABORT, 1'b0, 32'h0);
			rchk(ADDR_ABORT_CAUSE, 32'h3FFFF, 32'h0);
			flagchk(1'b0);
		end
		bus(ADDR_TARGET, 1'b1, 32'hC00);
		sb <= 1'b1;
		@(posedge clk);
		sb <= 1'b0;
		@(posedge clk);
		rchk(ADDR_ABORT_CAUSE, bitv(9), bitv(9));
		lows = 0;
		bus(ADDR_CLR_ABORT, 1'b0, 32'h0);
		repeat (2) @(posedge clk);
		check(lows, 32'h1);
		rchk(ADDR_ABORT_CAUSE, bitv(9), bitv(9));
		bus(ADDR_CONTROL, 1'b1, 32'h20);
		bus(ADDR_CLR_ALL, 1'b0, 32'h0);
		rchk(ADDR_ABORT_CAUSE, ALL, 32'h0);
		fifo <= 1'b1;
		src <= 1'b1;
		@(posedge clk);
		src <= 1'b0;
		@(negedge clk);
		check({31'h0, flush_request}, 32'h1);
		@(negedge clk);
		check({31'h0, flush_request}, 32'h0);
		@(posedge clk);
		rchk(ADDR_ABORT_CAUSE, bitv(13), bitv(13));
		fifo <= 1'b0;
		src <= 1'b1;
		@(posedge clk);
		src <= 1'b0;
		@(negedge clk);
		check({31'h0, flush_request}, 32'h0);
		@(posedge clk);
		bus(ADDR_ENABLE, 1'b1, 32'h1);
		bus(ADDR_SDA_HOLD, 1'b1, 32'h00550077);
		rchk(ADDR_SDA_HOLD, ALL, hv);
		check({31'h0, controller_enable}, 32'h1);
		flushes(3);
		rchk(ADDR_ABORT_CAUSE, CNT, 32'h01800000);
		flushes(6);
		rchk(ADDR_ABORT_CAUSE, CNT, CNT);
		bus(ADDR_ENABLE, 1'b1, 32'h3);
		rchk(ADDR_ABORT_CAUSE, bitv(16), bitv(16));
		bus(ADDR_ENABLE, 1'b1, 32'h0);
		rchk(ADDR_ABORT_CAUSE, CNT, 32'h0);
		check({31'h0, controller_enable}, 32'h0);
		complete_run();
	end
endmodule : tb_i2c_abort_hold
